// ---- pisl_status_latches.sv ----
/*
 * Primary request status latches: synchronises event sources, latches
 * sticky write-one-to-clear flags in ten status registers and drives
 * the first request output and the request pin.
 * Assumes a host on the same clock using a simple 16-bit register port
 * and mask/polarity levels supplied by neighbouring control logic.
 */
`timescale 1ns/10ps
module pisl_status_latches
    import pisl_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [PISL_AW-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [PISL_DW-1:0] reg_wdata_i,
    output logic [PISL_DW-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic [PISL_NREG-1:0][PISL_DW-1:0] src_mask_i,
    input wire logic req_pol_invert_i,
    input wire logic loop_lock_i,
    input wire logic [1:0] acc_detect_i,
    input wire logic hp_detect_done_i,
    input wire logic mic_clamp_i,
    input wire logic jack_detect_one_i,
    input wire logic jack_detect_two_i,
    input wire logic [3:0] rate_conv_lock_i,
    input wire logic input_sig_detect_i,
    input wire logic [1:0] comp_sig_detect_i,
    input wire logic [15:0] core_request_i,
    input wire logic [5:0] hp_short_i,
    input wire logic [5:0] hp_on_done_i,
    input wire logic [5:0] hp_off_done_i,
    input wire logic [15:0] gp_input_low_i,
    input wire logic [7:0] gp_input_high_i,
    output logic first_request_output_o,
    output logic request_pin_o
);

    localparam int SRC_W = 72;

    typedef struct packed {
        logic [PISL_DW-1:0] rdata;
        logic rvalid;
        logic req;
        logic pin;
    } pisl_top_t;

    logic [1:0] rst_sync_r;
    logic rst_n;
    pisl_top_t st_r;
    pisl_top_t st_nxt;
    logic [SRC_W-1:0] src_lvl;
    logic [SRC_W-1:0] src_rise;
    logic [SRC_W-1:0] src_fall;
    logic [PISL_NREG-1:0][PISL_DW-1:0] set_v;
    logic [PISL_NREG-1:0][PISL_DW-1:0] clr_v;
    logic [PISL_NREG-1:0][PISL_DW-1:0] flags;
    logic [PISL_NREG-1:0] hit;

    // unpacked views of the synchronised edges
    logic r_loop, r_hp, r_clamp, f_clamp, r_j1, f_j1, r_j2, f_j2;
    logic r_insig, f_insig;
    logic [1:0] r_acc, f_acc, r_comp, f_comp;
    logic [3:0] r_rcl, f_rcl;
    logic [15:0] r_core, f_core, r_gpl, f_gpl;
    logic [5:0] r_sc, f_sc, r_on, f_on, r_off, f_off;
    logic [7:0] r_gph, f_gph;
    logic f_loop, f_hp;

    // reset released through two flops; asserted without the clock
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // all sources may come from pins or slower domains
    assign src_lvl = {loop_lock_i, acc_detect_i, hp_detect_done_i,
        mic_clamp_i, jack_detect_one_i, jack_detect_two_i,
        rate_conv_lock_i, input_sig_detect_i, comp_sig_detect_i,
        core_request_i, hp_short_i, hp_on_done_i, hp_off_done_i,
        gp_input_low_i, gp_input_high_i};

    pisl_edge_sync #(
        .WIDTH(SRC_W)
    ) u_sync (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .level_i(src_lvl),
        .rise_o(src_rise),
        .fall_o(src_fall)
    );

    assign {r_loop, r_acc, r_hp, r_clamp, r_j1, r_j2, r_rcl, r_insig,
        r_comp, r_core, r_sc, r_on, r_off, r_gpl, r_gph} = src_rise;
    assign {f_loop, f_acc, f_hp, f_clamp, f_j1, f_j2, f_rcl, f_insig,
        f_comp, f_core, f_sc, f_on, f_off, f_gpl, f_gph} = src_fall;

    always_comb begin
        set_v = '0;
        set_v[IDX_LOOP][LOOP_LOCK_BIT] = r_loop;
        // detection event is taken as the rise of the detector's report
        set_v[IDX_DET][ACC_DET_LSB +: 2] = r_acc;
        set_v[IDX_DET][HP_DET_BIT] = r_hp;
        set_v[IDX_CLAMP][CLAMP_FALL_BIT] = f_clamp;
        set_v[IDX_CLAMP][CLAMP_RISE_BIT] = r_clamp;
        set_v[IDX_CLAMP][JACK2_FALL_BIT] = f_j2;
        set_v[IDX_CLAMP][JACK2_RISE_BIT] = r_j2;
        set_v[IDX_CLAMP][JACK1_FALL_BIT] = f_j1;
        set_v[IDX_CLAMP][JACK1_RISE_BIT] = r_j1;
        set_v[IDX_LOCK][RATE_LOCK_LSB +: 4] = r_rcl | f_rcl;
        set_v[IDX_LOCK][INPUT_SIG_BIT] = r_insig | f_insig;
        set_v[IDX_LOCK][COMP_SIG_LSB +: 2] = r_comp | f_comp;
        set_v[IDX_CORE][CORE_REQ_LSB +: 16] = r_core;
        set_v[IDX_SHORT][HP_CHAN_LSB +: 6] = r_sc;
        set_v[IDX_ON][HP_CHAN_LSB +: 6] = r_on;
        set_v[IDX_OFF][HP_CHAN_LSB +: 6] = r_off;
        set_v[IDX_GPLO][GP_LOW_LSB +: 16] = r_gpl | f_gpl;
        set_v[IDX_GPHI][GP_HIGH_LSB +: 8] = r_gph | f_gph;
    end

    genvar g;
    generate
        for (g = 0; g < PISL_NREG; g++) begin : g_bank
            assign hit[g] = (reg_addr_i == PISL_REG_ADDR[g]);
            // writing one clears, zero leaves the flag alone
            assign clr_v[g] = (reg_wr_i && hit[g]) ? reg_wdata_i
                : '0;
            // masked edges never reach the flag
            pisl_w1c_bank #(
                .IMPL(PISL_IMPL_MASK[g])
            ) u_bank (
                .clk_i(ref_clk_i),
                .rst_n_i(rst_n),
                .set_i(set_v[g]),
                .mask_i(src_mask_i[g]),
                .clr_i(clr_v[g]),
                .flags_o(flags[g])
            );
        end
    endgenerate

    always_comb begin
        st_nxt = st_r;
        st_nxt.rvalid = reg_rd_i;
        if (reg_rd_i) begin
            st_nxt.rdata = PISL_RDATA_RST;
            for (int i = 0; i < PISL_NREG; i++) begin
                if (hit[i]) begin
                    st_nxt.rdata = flags[i];
                end
            end
        end
        st_nxt.req = |flags;
        // default low-active pin, polarity flip on request
        st_nxt.pin = req_pol_invert_i ? st_nxt.req
            : ~st_nxt.req;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_r.rdata <= PISL_RDATA_RST;
            st_r.rvalid <= 1'b0;
            st_r.req <= 1'b0;
            st_r.pin <= PISL_PIN_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_o = st_r.rdata;
    assign reg_rvalid_o = st_r.rvalid;
    assign first_request_output_o = st_r.req;
    assign request_pin_o = st_r.pin;

    sequence s_loop_rise;
        r_loop && !src_mask_i[IDX_LOOP][LOOP_LOCK_BIT];
    endsequence

    sequence s_clamp_fall;
        f_clamp && !src_mask_i[IDX_CLAMP][CLAMP_FALL_BIT];
    endsequence

    sequence s_flag_then_req;
        (|flags) ##1 1'b1;
    endsequence

    loop_lock_set_a: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n) s_loop_rise |=> flags[IDX_LOOP][LOOP_LOCK_BIT])
        else $error("loop lock rise not latched");

    acc_two_set_a: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n)
        (r_acc[1] && !src_mask_i[IDX_DET][ACC_DET_LSB + 1])
        |=> flags[IDX_DET][ACC_DET_LSB + 1])
        else $error("accessory two event not latched");

    clamp_fall_a: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n) s_clamp_fall |=> flags[IDX_CLAMP][CLAMP_FALL_BIT])
        else $error("clamp fall not latched in bit five");

    jack_one_fall_a: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n)
        (f_j1 && !src_mask_i[IDX_CLAMP][JACK1_FALL_BIT] && !r_j1)
        |=> flags[IDX_CLAMP][JACK1_FALL_BIT])
        else $error("jack one fall not latched");

    rate_lock_fall_a: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n)
        (f_rcl[0] && !src_mask_i[IDX_LOCK][RATE_LOCK_LSB])
        |=> flags[IDX_LOCK][RATE_LOCK_LSB])
        else $error("rate converter fall not latched");

    gp_high_edge_a: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n)
        ((r_gph[7] || f_gph[7]) && !src_mask_i[IDX_GPHI][PISL_DW - 1])
        |=> flags[IDX_GPHI][PISL_DW - 1])
        else $error("input thirty-two edge not latched");

    flag_sticky_a: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n)
        (flags[IDX_CORE][0] && !clr_v[IDX_CORE][0])
        |=> flags[IDX_CORE][0])
        else $error("flag dropped without a one written");

    write_clear_a: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n)
        (clr_v[IDX_SHORT][0] && !set_v[IDX_SHORT][0])
        |=> !flags[IDX_SHORT][0])
        else $error("write of one did not clear flag");

    req_follows_a: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n)
        s_flag_then_req |-> first_request_output_o)
        else $error("request not raised for set flag");

    req_idle_a: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n)
        (!(|flags) ##1 !(|flags)) |-> !first_request_output_o)
        else $error("request raised with no flag set");

    mask_blocks_a: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n)
        (src_mask_i[IDX_GPLO][0] && !flags[IDX_GPLO][0])
        |=> !flags[IDX_GPLO][0])
        else $error("masked source set its flag");

    pin_polarity_a: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n)
        $stable(req_pol_invert_i) && !req_pol_invert_i
        |-> request_pin_o == !first_request_output_o)
        else $error("request pin not active low");

    reserved_zero_a: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n)
        (flags[IDX_GPHI] & ~PISL_IMPL_MASK[IDX_GPHI]) == '0)
        else $error("unlisted bit became set");

    hp_detect_set_a: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n)
        (r_hp && !src_mask_i[IDX_DET][HP_DET_BIT])
        |=> flags[IDX_DET][HP_DET_BIT])
        else $error("headphone detect rise not latched");

    input_sig_edge_a: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n)
        ((r_insig || f_insig) && !src_mask_i[IDX_LOCK][INPUT_SIG_BIT])
        |=> flags[IDX_LOCK][INPUT_SIG_BIT])
        else $error("input signal detect edge not latched");

    core_req_set_a: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n)
        (r_core[15] && !src_mask_i[IDX_CORE][CORE_REQ_LSB + 15])
        |=> flags[IDX_CORE][CORE_REQ_LSB + 15])
        else $error("core request sixteen not latched");

    gp_low_edge_a: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n)
        ((r_gpl[0] || f_gpl[0]) && !src_mask_i[IDX_GPLO][GP_LOW_LSB])
        |=> flags[IDX_GPLO][GP_LOW_LSB])
        else $error("input one edge not latched");

endmodule : pisl_status_latches

// ---- pisl_pkg.sv ----
/*
 * Constants for the primary request status latches: register offsets,
 * implemented-bit masks, field positions and reset values.
 * Assumes a 16-bit register port addressed by printed register offset.
 */
package pisl_pkg;

    localparam int PISL_NREG = 10;
    localparam int PISL_DW = 16;
    localparam int PISL_AW = 16;

    // register indices
    localparam int IDX_LOOP = 0;
    localparam int IDX_DET = 1;
    localparam int IDX_CLAMP = 2;
    localparam int IDX_LOCK = 3;
    localparam int IDX_CORE = 4;
    localparam int IDX_SHORT = 5;
    localparam int IDX_ON = 6;
    localparam int IDX_OFF = 7;
    localparam int IDX_GPLO = 8;
    localparam int IDX_GPHI = 9;

    localparam logic [15:0] PISL_REG_ADDR [PISL_NREG] = '{
        16'h1801, 16'h1805, 16'h1806, 16'h1808, 16'h180A,
        16'h180B, 16'h180C, 16'h180D, 16'h1810, 16'h1811};

    localparam logic [15:0] PISL_IMPL_MASK [PISL_NREG] = '{
        16'h0100, 16'h0301, 16'h003F, 16'h0F07, 16'hFFFF,
        16'h003F, 16'h003F, 16'h003F, 16'hFFFF, 16'hFF00};

    localparam logic [15:0] PISL_FLAG_RST = 16'h0000;
    localparam logic [15:0] PISL_RDATA_RST = 16'h0000;

    // field positions
    localparam int LOOP_LOCK_BIT = 8;
    localparam int ACC_DET_LSB = 8;
    localparam int HP_DET_BIT = 0;
    localparam int CLAMP_FALL_BIT = 5;
    localparam int CLAMP_RISE_BIT = 4;
    localparam int JACK2_FALL_BIT = 3;
    localparam int JACK2_RISE_BIT = 2;
    localparam int JACK1_FALL_BIT = 1;
    localparam int JACK1_RISE_BIT = 0;
    localparam int RATE_LOCK_LSB = 8;
    localparam int INPUT_SIG_BIT = 2;
    localparam int COMP_SIG_LSB = 0;
    localparam int CORE_REQ_LSB = 0;
    localparam int HP_CHAN_LSB = 0;
    localparam int GP_LOW_LSB = 0;
    localparam int GP_HIGH_LSB = 8;

    // request pin idles high under default polarity
    localparam logic PISL_PIN_RST = 1'b1;

endpackage : pisl_pkg

// ---- pisl_edge_sync.sv ----
/*
 * Three-stage synchroniser with edge detection for a vector of
 * asynchronous source levels. A change counts once stages two and
 * three agree. Assumes one clock and an already synchronised reset.
 */
`timescale 1ns/10ps
module pisl_edge_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] level_i,
    output logic [WIDTH-1:0] rise_o,
    output logic [WIDTH-1:0] fall_o
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } pisl_sync_t;

    pisl_sync_t st_r;
    pisl_sync_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = level_i;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // accepted level moves only when the two late stages agree
        st_nxt.lvl = (st_r.s2 & st_r.s3) | (st_r.lvl & (st_r.s2 | st_r.s3));
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rise_o = st_r.s2 & st_r.s3 & ~st_r.lvl;
    assign fall_o = ~st_r.s2 & ~st_r.s3 & st_r.lvl;

endmodule : pisl_edge_sync

// ---- pisl_w1c_bank.sv ----
/*
 * One 16-bit sticky, write-one-to-clear flag register.
 * Assumes set pulses and clear strobes are on the same clock.
 */
`timescale 1ns/10ps
module pisl_w1c_bank
    import pisl_pkg::*;
#(
    parameter logic [PISL_DW-1:0] IMPL = '1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [PISL_DW-1:0] set_i,
    input wire logic [PISL_DW-1:0] mask_i,
    input wire logic [PISL_DW-1:0] clr_i,
    output logic [PISL_DW-1:0] flags_o
);

    typedef struct packed {
        logic [PISL_DW-1:0] flags;
    } pisl_bank_t;

    pisl_bank_t st_r;
    pisl_bank_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        // set wins over a clear in the same cycle
        st_nxt.flags = ((st_r.flags & ~clr_i) | (set_i & ~mask_i)) & IMPL;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r.flags <= PISL_FLAG_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign flags_o = st_r.flags;

endmodule : pisl_w1c_bank

// ---- pisl_host.sv ----
/*
 * Host model: polls and clears the status flags over the register port.
 * Assumes a rising-edge register port with one-cycle strobes.
 */
`timescale 1ns/10ps
module pisl_host (
    input wire logic ref_clk_i,
    output logic [15:0] reg_addr_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [15:0] reg_wdata_o
);
    initial begin
        reg_addr_o = 16'h0000;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_wdata_o = 16'h0000;
    end

    // idle bus is scrambled so a stale address can never look valid
    task automatic access(input logic [15:0] a, input logic [15:0] d,
                          input logic w);
        @(negedge ref_clk_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = w;
        reg_rd_o = ~w;
        @(negedge ref_clk_i);
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask : access
endmodule : pisl_host

// ---- pisl_status_latches_tb.sv ----
/*
 * Self-checking bench for the status latches: random source edges,
 * masks and polarity, then polling and partial clears by the host.
 * Assumes the package, design and host model are compiled first.
 */
`timescale 1ns/10ps
module pisl_status_latches_tb
    import pisl_pkg::*;
;
    logic ref_clk_i, resetn_i, pol, wr, rd, rvalid, req, pin;
    logic [15:0] addr, wdata, rdata, seed, r16;
    logic [PISL_NREG-1:0][PISL_DW-1:0] mask;
    logic [71:0] src, src_old, nxt;
    logic [15:0] flg [PISL_NREG];
    logic [15:0] rq [$];
    int n_fail, num_checks;

    pisl_status_latches dut (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .src_mask_i(mask),
        .req_pol_invert_i(pol), .loop_lock_i(src[0]),
        .acc_detect_i(src[2:1]), .hp_detect_done_i(src[3]),
        .mic_clamp_i(src[4]), .jack_detect_one_i(src[5]),
        .jack_detect_two_i(src[6]), .rate_conv_lock_i(src[10:7]),
        .input_sig_detect_i(src[11]), .comp_sig_detect_i(src[13:12]),
        .core_request_i(src[29:14]), .hp_short_i(src[35:30]),
        .hp_on_done_i(src[41:36]), .hp_off_done_i(src[47:42]),
        .gp_input_low_i(src[63:48]), .gp_input_high_i(src[71:64]),
        .first_request_output_o(req), .request_pin_o(pin));

    pisl_host host (.ref_clk_i(ref_clk_i), .reg_addr_o(addr),
        .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata));

    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction : rnd

    // flag events a source change produces, per register index
    function automatic logic [15:0] ev(input int k, input logic [71:0] o,
                                       input logic [71:0] n);
        logic [71:0] r, f, b;
        r = n & ~o;
        f = o & ~n;
        b = r | f;
        case (k)
            0: ev = {7'h00, r[0], 8'h00};
            1: ev = {6'h00, r[2:1], 7'h00, r[3]};
            2: ev = {10'h000, f[4], r[4],
                     f[6], r[6], f[5], r[5]};
            3: ev = {4'h0, b[10:7], 5'h00,
                     b[11], b[13:12]};
            4: ev = r[29:14];
            5: ev = {10'h000, r[35:30]};
            6: ev = {10'h000, r[41:36]};
            7: ev = {10'h000, r[47:42]};
            8: ev = b[63:48];
            default: ev = {b[71:64], 8'h00};
        endcase
    endfunction : ev

    task automatic cmp16(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp16

    task automatic cmp_req(input logic exp);
        num_checks++;
        if (req !== exp || pin !== (exp ^ ~pol)) begin
            n_fail++;
            $display("MISMATCH request expected %b%b seen %b%b",
                     exp, exp ^ ~pol, req, pin);
        end
    endtask : cmp_req

    always @(negedge ref_clk_i) begin
        if (rvalid === 1'b1) begin
            if (rq.size() == 0) begin
                n_fail++;
                $display("MISMATCH read valid expected 0 seen 1");
            end else begin
                cmp16("read data", rq.pop_front(), rdata);
            end
        end
    end

    task automatic read_chk(input logic [15:0] a, input logic [15:0] exp);
        rq.push_back(exp);
        host.access(a, 16'h0000, 1'b0);
    endtask : read_chk

    task automatic check_all();
        logic any;
        any = 1'b0;
        for (int k = 0; k < PISL_NREG; k++) begin
            read_chk(PISL_REG_ADDR[k], flg[k]);
            any = any | (|flg[k]);
        end
        read_chk(16'h1802, 16'h0000);
        repeat (3) @(negedge ref_clk_i);
        // every read must have been answered by now
        cmp16("unanswered reads", 16'h0000, 16'(rq.size()));
        cmp_req(any);
    endtask : check_all

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (40000) @(negedge ref_clk_i);
        n_fail++;
        $display("MISMATCH watchdog expected done seen timeout");
        summarize();
    end

    initial begin
        n_fail = 0;
        num_checks = 0;
        seed = 16'hF300;
        resetn_i = 1'b0;
        pol = 1'b0;
        mask = '0;
        src = '0;
        nxt = '0;
        for (int k = 0; k < PISL_NREG; k++) flg[k] = PISL_FLAG_RST;
        repeat (20) @(negedge ref_clk_i);
        resetn_i = 1'b1;
        repeat (5) @(negedge ref_clk_i);
        check_all();
        $display("test reset values done");
        for (int i = 0; i < 40; i++) begin
            @(negedge ref_clk_i);
            src_old = src;
            for (int j = 0; j < 5; j++) nxt = {nxt[55:0], rnd()};
            src = nxt;
            for (int k = 0; k < PISL_NREG; k++) mask[k] = rnd() & rnd();
            r16 = rnd();
            pol = r16[0];
            // sources hold well past the three-stage synchroniser
            repeat (8) @(negedge ref_clk_i);
            for (int k = 0; k < PISL_NREG; k++) begin
                r16 = ev(k, src_old, src) & ~mask[k];
                flg[k] = flg[k] | r16;
            end
            check_all();
            host.access(16'h1802, 16'hFFFF, 1'b1);
            for (int k = 0; k < PISL_NREG; k++) begin
                r16 = rnd();
                host.access(PISL_REG_ADDR[k], r16, 1'b1);
                flg[k] = flg[k] & ~r16;
            end
        end
        check_all();
        $display("test random edges done");
        for (int k = 0; k < PISL_NREG; k++) begin
            host.access(PISL_REG_ADDR[k], 16'hFFFF, 1'b1);
            flg[k] = 16'h0000;
        end
        check_all();
        $display("test clear all done");
        summarize();
    end
endmodule : pisl_status_latches_tb
